// *** logic/i4r_ctrl.sv ***
/*
 * remote/local, addressing, device clear, trigger and service request
 * logic of an instrument bus port, with an apb register slave.
 * assumes bus bytes arrive already handshaken as one-cycle pulses
 * synchronous to pclk, and the parser reports local/remote commands.
 */
`include "i4r_map.svh"
`timescale 1ns/1ps
`default_nettype none

module i4r_ctrl (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // instrument bus side
    input wire logic atn,
    input wire logic ren,
    input wire logic ifc,
    input wire logic bus_byte_valid,
    input wire logic [7:0] bus_byte,
    // instrument side
    input wire logic local_key,
    input wire logic prog_local,
    input wire logic prog_remote,
    input wire logic trig_cmd,
    input wire logic spoll_done,
    input wire logic out_avail,
    input wire logic [15:0] hw_event,
    input wire logic [7:0] esr_event,
    // outputs
    output logic remote_indicator,
    output logic lockout,
    output logic listen_active,
    output logic talk_active,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic dev_clear,
    output logic meas_start,
    output logic srq,
    output logic irq,
    output logic [15:0] learn_word
);
    // ********************************
    // state
    // ********************************
    i4r_pkg::i4r_rl_state_t rl_q, rl_d;
    logic lock_q, listen_q, talk_q, tonly_q, sum_q, srq_q;
    logic [4:0] addr_q;
    logic [15:0] hsr_q, hse_q;
    logic [7:0] esr_q, ese_q, sre_q;
    logic [`I4R_NUM_EVT-1:0] ist_q, ien_q;
    logic [31:0] prdata_q;
    logic rx_valid_q, dclr_q, meas_q;
    logic [7:0] rx_byte_q;
    logic [15:0] learn_q;

    // ********************************
    // bus byte decode
    // ********************************
    wire cmd_in = bus_byte_valid & atn & ~tonly_q;
    wire dat_in = bus_byte_valid & ~atn & ~tonly_q;
    wire is_mla = cmd_in & (bus_byte == {`I4R_LAG_BASE, addr_q});
    wire is_mta = cmd_in & (bus_byte == {`I4R_TAG_BASE, addr_q});
    wire is_unl = cmd_in & (bus_byte == `I4R_CMD_UNL);
    wire is_unt = cmd_in & (bus_byte == `I4R_CMD_UNT);
    wire is_gtl = cmd_in & listen_q & (bus_byte == `I4R_CMD_GTL);
    wire is_llo = cmd_in & (bus_byte == `I4R_CMD_LLO);
    wire is_dcl = cmd_in & (bus_byte == `I4R_CMD_DCL);
    wire is_sdc = cmd_in & listen_q & (bus_byte == `I4R_CMD_SDC);
    wire is_get = cmd_in & listen_q & (bus_byte == `I4R_CMD_GET);
    wire ren_low = ~ren & ~tonly_q;
    wire ifc_in = ifc & ~tonly_q;

    // ********************************
    // remote / local
    // ********************************
    // local requests win over remote requests in the same cycle
    wire go_local = ren_low | is_gtl | prog_local | (local_key & ~lock_q);
    wire go_remote = (is_mla & ren) | prog_remote;
    wire to_local = (rl_q == i4r_pkg::ST_REMOTE) & go_local;
    wire to_remote = (rl_q == i4r_pkg::ST_LOCAL) & go_remote & ~go_local;

    always_comb begin
        case (rl_q)
            i4r_pkg::ST_LOCAL: rl_d = to_remote ? i4r_pkg::ST_REMOTE : i4r_pkg::ST_LOCAL;
            i4r_pkg::ST_REMOTE: rl_d = to_local ? i4r_pkg::ST_LOCAL : i4r_pkg::ST_REMOTE;
            default: rl_d = i4r_pkg::ST_LOCAL;
        endcase
    end

    // ********************************
    // apb decode
    // ********************************
    wire wr = psel & penable & pwrite & clk_en;
    wire setup_rd = psel & ~penable & ~pwrite & clk_en;
    wire hit = (paddr <= `I4R_OFS_IRQ_EN) & (paddr[1:0] == 2'b00);
    wire wr_cfg = wr & (paddr == `I4R_OFS_CFG);
    wire wr_hsr = wr & (paddr == `I4R_OFS_HSR);
    wire wr_hse = wr & (paddr == `I4R_OFS_HSE);
    wire wr_esr = wr & (paddr == `I4R_OFS_ESR);
    wire wr_ese = wr & (paddr == `I4R_OFS_ESE);
    wire wr_sre = wr & (paddr == `I4R_OFS_SRE);
    wire wr_iclr = wr & (paddr == `I4R_OFS_IRQ_CLR);
    wire wr_ien = wr & (paddr == `I4R_OFS_IRQ_EN);

    // ********************************
    // status reporting
    // ********************************
    wire hsb = |(hsr_q & hse_q);
    wire esb = |(esr_q & ese_q);
    wire [7:0] stb = {1'b0, srq_q, esb, out_avail, 3'h0, hsb};
    // rqs itself is left out so the summary cannot feed back on itself
    wire sum = |(stb & sre_q & ~(8'h01 << `I4R_STB_RQS_BIT));
    wire srq_rise = sum & ~sum_q;
    wire [`I4R_NUM_EVT-1:0] evt = {srq_rise, is_get, is_dcl | is_sdc, to_remote, to_local};
    wire [31:0] state_word = {28'h0, talk_q, listen_q, lock_q, rl_q == i4r_pkg::ST_REMOTE};
    wire [15:0] learn_d = {8'h0, tonly_q, lock_q, addr_q, 1'b0};

    wire [31:0] rd_mux =
        (paddr == `I4R_OFS_CFG) ? {26'h0, tonly_q, addr_q} :
        (paddr == `I4R_OFS_STATE) ? state_word :
        (paddr == `I4R_OFS_HSR) ? {16'h0, hsr_q} :
        (paddr == `I4R_OFS_HSE) ? {16'h0, hse_q} :
        (paddr == `I4R_OFS_ESR) ? {24'h0, esr_q} :
        (paddr == `I4R_OFS_ESE) ? {24'h0, ese_q} :
        (paddr == `I4R_OFS_STB) ? {24'h0, stb} :
        (paddr == `I4R_OFS_SRE) ? {24'h0, sre_q} :
        (paddr == `I4R_OFS_IRQ_STAT) ? {27'h0, ist_q} :
        (paddr == `I4R_OFS_IRQ_EN) ? {27'h0, ien_q} : 32'h0;

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rl_q <= i4r_pkg::ST_LOCAL;
            lock_q <= 1'b0;
            listen_q <= 1'b0;
            talk_q <= 1'b0;
            tonly_q <= 1'b0;
            addr_q <= `I4R_ADDR_RST;
            hsr_q <= 16'h0;
            hse_q <= 16'h0;
            esr_q <= 8'h0;
            ese_q <= 8'h0;
            sre_q <= 8'h0;
            sum_q <= 1'b0;
            srq_q <= 1'b0;
            ien_q <= '0;
            prdata_q <= 32'h0;
        end else if (clk_en) begin
            // settings live apart from the remote state, so no transition edits them
            rl_q <= rl_d;
            if (ren_low) begin
                lock_q <= 1'b0;
            end else if (is_llo) begin
                lock_q <= 1'b1;
            end
            if (ifc_in | is_unl) begin
                listen_q <= 1'b0;
            end else if (is_mla) begin
                listen_q <= 1'b1;
            end
            if (ifc_in | is_unt | is_mla) begin
                talk_q <= 1'b0;
            end else if (is_mta) begin
                talk_q <= 1'b1;
            end
            if (wr_cfg) begin
                addr_q <= pwdata[4:0];
                tonly_q <= pwdata[`I4R_CFG_TONLY_BIT];
            end
            hsr_q <= (hsr_q & ~(wr_hsr ? pwdata[15:0] : 16'h0)) | hw_event;
            esr_q <= (esr_q & ~(wr_esr ? pwdata[7:0] : 8'h0)) | esr_event;
            if (wr_hse) hse_q <= pwdata[15:0];
            if (wr_ese) ese_q <= pwdata[7:0];
            if (wr_sre) sre_q <= pwdata[7:0];
            if (wr_ien) ien_q <= pwdata[`I4R_NUM_EVT-1:0];
            sum_q <= sum;
            srq_q <= srq_rise | (srq_q & ~spoll_done);
            if (setup_rd) prdata_q <= rd_mux;
        end
    end

    // sticky event bits, a set beats a clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < `I4R_NUM_EVT; gi = gi + 1) begin : g_ist
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ist_q[gi] <= 1'b0;
                end else if (clk_en) begin
                    ist_q[gi] <= evt[gi] | (ist_q[gi] & ~(wr_iclr & pwdata[gi]));
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_valid_q <= 1'b0;
            rx_byte_q <= 8'h0;
            dclr_q <= 1'b0;
            meas_q <= 1'b0;
            learn_q <= 16'h0;
        end else if (clk_en) begin
            rx_valid_q <= dat_in & listen_q & (rl_q == i4r_pkg::ST_REMOTE);
            if (dat_in) rx_byte_q <= bus_byte;
            dclr_q <= is_dcl | is_sdc;
            meas_q <= is_get | trig_cmd;
            learn_q <= learn_d;
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign prdata = prdata_q;
    // a frozen block stalls the bus rather than lose a write
    assign pready = clk_en;
    assign pslverr = psel & penable & ~hit;
    assign remote_indicator = (rl_q == i4r_pkg::ST_REMOTE);
    assign lockout = lock_q;
    assign listen_active = listen_q;
    assign talk_active = talk_q | tonly_q;
    assign rx_valid = rx_valid_q;
    assign rx_byte = rx_byte_q;
    assign dev_clear = dclr_q;
    assign meas_start = meas_q;
    assign srq = srq_q;
    assign irq = |(ist_q & ien_q);
    assign learn_word = learn_q;

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_gtl_local;
        clk_en && remote_indicator && is_gtl |=> !remote_indicator;
    endproperty
    a_gtl_local: assert property (p_gtl_local) else $error("gtl left device remote");

    property p_ren_local;
        clk_en && !ren && !tonly_q |=> !remote_indicator && !lockout;
    endproperty
    a_ren_local: assert property (p_ren_local) else $error("ren low kept remote");

    property p_key_lockout;
        clk_en && remote_indicator && lockout && local_key && ren && !is_gtl
            && !prog_local |=> remote_indicator;
    endproperty
    a_key_lockout: assert property (p_key_lockout) else $error("local key beat lockout");

    property p_unt_talk;
        clk_en && is_unt && !tonly_q |=> !talk_q;
    endproperty
    a_unt_talk: assert property (p_unt_talk) else $error("untalk did not end talk");

    property p_rx_gate;
        rx_valid |-> $past(listen_q) && $past(remote_indicator) && !$past(atn);
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("data taken while not allowed");

    property p_dcl_pulse;
        clk_en && is_dcl ##1 clk_en |-> dev_clear ##1 !dev_clear;
    endproperty
    a_dcl_pulse: assert property (p_dcl_pulse) else $error("device clear pulse wrong");

    property p_get_meas;
        clk_en && is_get |=> meas_start;
    endproperty
    a_get_meas: assert property (p_get_meas) else $error("trigger did not start");

    property p_mla_remote;
        clk_en && is_mla && ren && !ifc && !go_local |=> remote_indicator && listen_active;
    endproperty
    a_mla_remote: assert property (p_mla_remote) else $error("listen address missed remote");

    property p_srq_edge;
        $rose(srq) |-> $past(sum) && !$past(sum_q);
    endproperty
    a_srq_edge: assert property (p_srq_edge) else $error("srq without rising summary");

    property p_tonly_ignore;
        clk_en && tonly_q && bus_byte_valid && !wr_cfg
            |=> !rx_valid && !dev_clear && talk_active;
    endproperty
    a_tonly_ignore: assert property (p_tonly_ignore) else $error("talk-only took bus byte");

    property p_ifc_clear;
        clk_en && ifc && !tonly_q |=> !listen_active && !talk_q;
    endproperty
    a_ifc_clear: assert property (p_ifc_clear) else $error("ifc kept device addressed");

    property p_trig_meas;
        clk_en && trig_cmd |=> meas_start;
    endproperty
    a_trig_meas: assert property (p_trig_meas) else $error("trigger command did not start");

    property p_llo_lock;
        clk_en && is_llo && ren |=> lockout;
    endproperty
    a_llo_lock: assert property (p_llo_lock) else $error("lockout command not taken");

    c_remote_local: cover property (remote_indicator ##[1:20] !remote_indicator);
    c_talk_only: cover property (tonly_q && bus_byte_valid);
    c_srq: cover property ($rose(srq));
    c_rx: cover property (rx_valid);
    c_lockout_key: cover property (lockout && remote_indicator && local_key);
endmodule // i4r_ctrl

`default_nettype wire

// *** logic/i4r_map.svh ***
/*
 * offsets, field positions, reset values and bus command codes of the
 * remote/local control block.
 * assumes a 32-bit apb slave with word-aligned registers.
 */
`ifndef I4R_MAP_SVH
`define I4R_MAP_SVH

// ********************************
// register offsets
// ********************************
`define I4R_OFS_CFG 8'h00
`define I4R_OFS_STATE 8'h04
`define I4R_OFS_HSR 8'h08
`define I4R_OFS_HSE 8'h0c
`define I4R_OFS_ESR 8'h10
`define I4R_OFS_ESE 8'h14
`define I4R_OFS_STB 8'h18
`define I4R_OFS_SRE 8'h1c
`define I4R_OFS_IRQ_STAT 8'h20
`define I4R_OFS_IRQ_CLR 8'h24
`define I4R_OFS_IRQ_EN 8'h28

// ********************************
// fields and reset values
// ********************************
`define I4R_CFG_TONLY_BIT 5
`define I4R_ADDR_RST 5'h03
`define I4R_STB_HSB_BIT 0
`define I4R_STB_MAV_BIT 4
`define I4R_STB_ESB_BIT 5
`define I4R_STB_RQS_BIT 6
`define I4R_NUM_EVT 5

// ********************************
// interface commands, atn asserted
// ********************************
`define I4R_CMD_GTL 8'h01
`define I4R_CMD_SDC 8'h04
`define I4R_CMD_GET 8'h08
`define I4R_CMD_LLO 8'h11
`define I4R_CMD_DCL 8'h14
`define I4R_CMD_UNL 8'h3f
`define I4R_CMD_UNT 8'h5f
`define I4R_LAG_BASE 3'h1
`define I4R_TAG_BASE 3'h2

`endif

// *** logic/i4r_pkg.sv ***
/*
 * types of the remote/local control block.
 * assumes nothing of its surroundings.
 */
package i4r_pkg;
    typedef enum logic [0:0] {
        ST_LOCAL = 1'b0,
        ST_REMOTE = 1'b1
    } i4r_rl_state_t;
endpackage

// *** verification/i4r_ctl_model.sv ***
/*
 * behavioural model of the bus controller facing the remote/local block.
 * assumes the bench calls its tasks from one process, one byte at a time.
 */
`timescale 1ns/1ps
`default_nettype none

module i4r_ctl_model (
    // clock
    input wire logic pclk,
    // bus lines
    output var logic atn,
    output var logic ren,
    output var logic ifc,
    output var logic bus_byte_valid,
    output var logic [7:0] bus_byte
);
    // ********************************
    // controller actions
    // ********************************
    initial begin
        atn = 1'b0;
        ren = 1'b0;
        ifc = 1'b0;
        bus_byte_valid = 1'b0;
        bus_byte = 8'h00;
    end

    // one byte per call; atn picks command or data mode
    task automatic send(input logic cmd, input logic [7:0] b);
        @(posedge pclk);
        atn <= cmd;
        bus_byte <= b;
        bus_byte_valid <= 1'b1;
        @(posedge pclk);
        bus_byte_valid <= 1'b0;
        // released lines must not keep showing the last byte
        bus_byte <= ~b;
    endtask

    task automatic lines(input logic r, input logic i);
        @(posedge pclk);
        ren <= r;
        ifc <= i;
    endtask
endmodule // i4r_ctl_model

`default_nettype wire

// *** verification/ieee488_remote_local_control_test.sv ***
/*
 * self-checking bench of the remote/local block: apb tasks, bus model.
 * assumes the design header and package are compiled first.
 */
`include "i4r_map.svh"
`timescale 1ns/1ps
`default_nettype none

module ieee488_remote_local_control_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, atn, ren, ifc, bv, err, rem, lock, lis, tlk;
    logic rx_valid, dclr, mst, srq, irq;
    logic [7:0] bb, rx_byte, last_rx;
    logic [15:0] lw;
    logic [4:0] pl = 5'h00;
    logic oa = 1'b0;
    logic ce = 1'b1;
    logic [15:0] hw = 16'h0000;
    logic [7:0] es = 8'h00;
    int fail_count = 0, n_checks = 0, n_rx = 0, n_dc = 0, n_ms = 0;

    always #4 pclk = ~pclk;

    // pulses are counted so their exact cycle need not be guessed
    always @(posedge pclk) begin
        if (rx_valid === 1'b1) begin
            n_rx++;
            last_rx = rx_byte;
        end
        if (dclr === 1'b1) n_dc++;
        if (mst === 1'b1) n_ms++;
    end

    i4r_ctl_model i4r_ctl_model_i (.pclk(pclk), .atn(atn), .ren(ren), .ifc(ifc),
        .bus_byte_valid(bv), .bus_byte(bb));

    i4r_ctrl i4r_ctrl_i (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .atn(atn), .ren(ren),
        .ifc(ifc), .bus_byte_valid(bv), .bus_byte(bb), .local_key(pl[0]),
        .prog_local(pl[1]), .prog_remote(pl[2]), .trig_cmd(pl[4]), .spoll_done(pl[3]),
        .out_avail(oa), .hw_event(hw), .esr_event(es),
        .remote_indicator(rem), .lockout(lock), .listen_active(lis),
        .talk_active(tlk), .rx_valid(rx_valid), .rx_byte(rx_byte), .dev_clear(dclr),
        .meas_start(mst), .srq(srq), .irq(irq), .learn_word(lw));

    // ********************************
    // tasks
    // ********************************
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1) begin
            fail_count++;
            close_out;
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic pulse(input int i);
        @(posedge pclk);
        pl[i] <= 1'b1;
        @(posedge pclk);
        pl[i] <= 1'b0;
        wt(3);
    endtask

    task automatic cmd(input logic [7:0] b);
        i4r_ctl_model_i.send(1'b1, b);
        wt(3);
    endtask

    // one-cycle pulses into the status registers
    task automatic ev(input logic [15:0] h, input logic [7:0] e);
        @(posedge pclk);
        hw <= h;
        es <= e;
        @(posedge pclk);
        hw <= 16'h0000;
        es <= 8'h00;
        wt(3);
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        close_out;
    end

    // ********************************
    // sequence
    // ********************************
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`I4R_OFS_CFG, 32'h3);
        chk(32'(lw), 32'h6);
        chk(32'(rem), 32'h0);
        i4r_ctl_model_i.lines(1'b1, 1'b0);
        cmd(8'h23);
        chk(32'({rem, lis}), 32'h3);
        rdchk(`I4R_OFS_STATE, 32'h5);
        i4r_ctl_model_i.send(1'b0, 8'h5a);
        wt(3);
        chk(n_rx, 32'd1);
        chk(32'(last_rx), 32'h5a);
        cmd(`I4R_CMD_GTL);
        chk(32'({rem, lis}), 32'h1);
        i4r_ctl_model_i.send(1'b0, 8'h33);
        wt(3);
        chk(n_rx, 32'd1);
        rdchk(`I4R_OFS_CFG, 32'h3);
        cmd(8'h23);
        i4r_ctl_model_i.lines(1'b0, 1'b0);
        wt(2);
        chk(32'(rem), 32'h0);
        i4r_ctl_model_i.lines(1'b1, 1'b0);
        cmd(8'h23);
        cmd(`I4R_CMD_LLO);
        chk(32'(lw), 32'h46);
        pulse(0);
        chk(32'({rem, lock}), 32'h3);
        pulse(1);
        chk(32'(rem), 32'h0);
        pulse(2);
        chk(32'(rem), 32'h1);
        pulse(1);
        chk(32'(rem), 32'h0);
        i4r_ctl_model_i.lines(1'b0, 1'b0);
        i4r_ctl_model_i.lines(1'b1, 1'b0);
        wt(2);
        cmd(8'h43);
        chk(32'(tlk), 32'h1);
        cmd(8'h23);
        chk(32'({tlk, lis}), 32'h1);
        cmd(8'h43);
        cmd(`I4R_CMD_UNT);
        chk(32'(tlk), 32'h0);
        i4r_ctl_model_i.lines(1'b1, 1'b1);
        i4r_ctl_model_i.lines(1'b1, 1'b0);
        wt(2);
        chk(32'(lis), 32'h0);
        cmd(`I4R_CMD_DCL);
        chk(n_dc, 32'd1);
        cmd(8'h23);
        cmd(`I4R_CMD_SDC);
        chk(n_dc, 32'd2);
        cmd(`I4R_CMD_GET);
        chk(n_ms, 32'd1);
        // a frozen block lets a bus byte pass by untaken
        @(posedge pclk);
        ce <= 1'b0;
        cmd(`I4R_CMD_GET);
        chk(n_ms, 32'd1);
        @(posedge pclk);
        ce <= 1'b1;
        pulse(4);
        chk(n_ms, 32'd2);
        apb(1'b1, `I4R_OFS_HSE, 32'hffff);
        rdchk(`I4R_OFS_HSE, 32'hffff);
        apb(1'b1, `I4R_OFS_SRE, 32'h10);
        oa <= 1'b1;
        wt(3);
        chk(32'({srq, irq}), 32'h2);
        rdchk(`I4R_OFS_STB, 32'h50);
        apb(1'b1, `I4R_OFS_IRQ_EN, 32'h10);
        wt(1);
        chk(32'(irq), 32'h1);
        pulse(3);
        chk(32'(srq), 32'h0);
        apb(1'b1, `I4R_OFS_IRQ_CLR, 32'h10);
        wt(1);
        chk(32'(irq), 32'h0);
        apb(1'b1, `I4R_OFS_SRE, 32'h01);
        ev(16'h0004, 8'h02);
        chk(32'(srq), 32'h1);
        rdchk(`I4R_OFS_HSR, 32'h4);
        rdchk(`I4R_OFS_ESR, 32'h2);
        rdchk(`I4R_OFS_STB, 32'h51);
        pulse(3);
        apb(1'b1, `I4R_OFS_HSR, 32'h4);
        rdchk(`I4R_OFS_HSR, 32'h0);
        apb(1'b1, `I4R_OFS_HSE, 32'h0);
        ev(16'h0004, 8'h00);
        chk(32'(srq), 32'h0);
        cmd(`I4R_CMD_UNL);
        apb(1'b1, `I4R_OFS_CFG, 32'h23);
        wt(2);
        cmd(8'h23);
        chk(32'({tlk, lis}), 32'h2);
        chk(32'(lw), 32'h86);
        i4r_ctl_model_i.lines(1'b0, 1'b0);
        wt(2);
        chk(32'(rem), 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
        close_out;
    end
endmodule // ieee488_remote_local_control_test

`default_nettype wire
